// >>> include/ethernet_reset_pkg.sv
// Constants for the Ethernet reset and register-write control block.
// Assumes a 32-bit AXI4-Lite register port with byte addresses below 0x100.
package ethernet_reset_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] KERNEL_RESET_CTRL_A_OFF   = 8'h00;
  localparam logic [7:0] KERNEL_RESET_CTRL_B_OFF   = 8'h04;
  localparam logic [7:0] KERNEL_RESET_FLAG_CLR_OFF = 8'h08;
  localparam logic [7:0] PORT_CONTROL_OFF          = 8'h0C;
  localparam logic [7:0] DMA_MODE_OFF              = 8'h10;
  localparam logic [7:0] INIT_LOCK_OFF             = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int unsigned RESET_REQ_BIT   = 0;
  localparam int unsigned RESET_FLAG_BIT  = 1;
  localparam int unsigned FLAG_CLEAR_BIT  = 0;
  localparam int unsigned PHY_SEL_LSB     = 0;
  localparam int unsigned PHY_SEL_W       = 2;
  localparam int unsigned SOFT_RESET_BIT  = 0;
  localparam int unsigned LOCK_BIT        = 0;
  localparam int unsigned PRIV_PROT_BIT   = 0;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned ADDR_W          = 8;

  // ==========================================================================
  // Reset values and encodings
  localparam logic [PHY_SEL_W-1:0] PHY_SEL_MII   = 2'h0;
  localparam logic [PHY_SEL_W-1:0] PHY_SEL_RMII  = 2'h1;
  localparam logic                 LOCK_RESET    = 1'b1;
  localparam logic [1:0]           RESP_OKAY     = 2'h0;
  localparam logic [1:0]           RESP_SLVERR   = 2'h2;

  // ==========================================================================
  // Timing
  localparam int unsigned LINK_RESET_CYCLES = 8;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_HOLD = 2'b01,
    LINK_DONE = 2'b11
  } link_state_e;

endpackage : ethernet_reset_pkg

// >>> hdl/link_reset_bridge.sv
// Link-clock side: applies the link-domain reset and takes configuration words.
// Assumes request toggles and the word come from flip-flops on the bus clock,
// the word held steady until its acknowledge toggle returns.
`timescale 1ns/10ps
module link_reset_bridge #(
  parameter int unsigned CFG_W       = 2,
  parameter int unsigned HOLD_CYCLES = 8
) (
  input  wire logic             link_clk,
  input  wire logic             aresetn,
  input  wire logic             rst_tgl,
  input  wire logic             cfg_tgl,
  input  wire logic [CFG_W-1:0] cfg_data,
  output logic                  rst_ack,
  output logic                  cfg_ack,
  output logic                  link_reset,
  output logic      [CFG_W-1:0] link_cfg
);

  localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);

  generate
    if (CFG_W < 1 || HOLD_CYCLES < 1) begin : g_bad
      $error("link_reset_bridge: CFG_W and HOLD_CYCLES must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic                              rm;
    logic                              rs;
    logic                              tm;
    logic                              ts;
    logic                              tp;
    logic                              cm;
    logic                              cs;
    logic                              cp;
    ethernet_reset_pkg::link_state_e   state;
    logic [CW-1:0]                     cnt;
    logic                              rack;
    logic                              cack;
    logic                              lrst;
    logic [CFG_W-1:0]                  cfg;
  } link_s;

  link_s q;
  link_s d;

  // ==========================================================================
  // Next state
  always_comb begin
    d    = q;
    d.rm = aresetn;
    d.rs = q.rm;
    d.tm = rst_tgl;
    d.ts = q.tm;
    d.cm = cfg_tgl;
    d.cs = q.cm;
    if (!q.rs) begin
      d.tp    = 1'b0;
      d.cp    = 1'b0;
      d.state = ethernet_reset_pkg::LINK_IDLE;
      d.cnt   = '0;
      d.rack  = 1'b0;
      d.cack  = 1'b0;
      d.lrst  = 1'b0;
      d.cfg   = '0;
    end else begin
      unique case (q.state)
        ethernet_reset_pkg::LINK_IDLE: begin
          if (q.ts != q.tp) begin
            d.tp    = q.ts;
            d.state = ethernet_reset_pkg::LINK_HOLD;
            d.cnt   = CW'(HOLD_CYCLES - 1);
            d.lrst  = 1'b1; // [RULE13]
          end
        end
        ethernet_reset_pkg::LINK_HOLD: begin
          if (q.cnt == '0) begin
            d.state = ethernet_reset_pkg::LINK_DONE;
            d.lrst  = 1'b0;
          end else begin
            d.cnt = q.cnt - CW'(1);
          end
        end
        ethernet_reset_pkg::LINK_DONE: begin
          d.rack  = ~q.rack; // [RULE13]
          d.state = ethernet_reset_pkg::LINK_IDLE;
        end
        default: begin
          d.state = ethernet_reset_pkg::LINK_IDLE;
          d.lrst  = 1'b0;
        end
      endcase
      if (q.cs != q.cp) begin
        d.cp   = q.cs;
        d.cfg  = cfg_data;
        d.cack = ~q.cack;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    q <= d;
  end

  assign rst_ack    = q.rack;
  assign cfg_ack    = q.cack;
  assign link_reset = q.lrst;
  assign link_cfg   = q.cfg;

endmodule : link_reset_bridge

// >>> hdl/ethernet_reset_and_reg_sync.sv
// Reset and register-write control for the Ethernet module, AXI4-Lite slave.
// Assumes the PHY clock runs on link_clk whenever a reset must complete.
`timescale 1ns/10ps

// Behaviour
// [RULE1] Surroundings keep PHY interface clocks running during kernel or soft reset.
// [RULE2] Software lets transfers finish and sees DMA process states stopped first.
// [RULE3] Software waits 70 bus cycles after reset before checking receive queues.
// [RULE4] Software finishes running interrupt and disables interrupts before kernel reset.
// [RULE5] Kernel reset registers written only privileged and with init lock off.
// [RULE6] Both request bits request kernel reset; flag set, cleared by clear bit.
// [RULE7] Software reprograms the same PHY interface select after kernel reset.
// [RULE8] Soft reset request bit self-clears when done; software polls it after 4 cycles.
// [RULE9] From power-on, software may skip kernel reset and only soft reset.
// [RULE10] Too-quick second write misses the destination domain, readback shows new value.
// [RULE11] Software spaces same-register writes by 6 destination clock cycles.
// [RULE12] Write spacing is counted in the slowest of the destination clocks.
// [RULE13] Soft reset bit reads one until link-domain reset applied and released.
module ethernet_reset_and_reg_sync #(
  parameter int unsigned LINK_HOLD = ethernet_reset_pkg::LINK_RESET_CYCLES
) (
  input  wire logic                                       aclk,
  input  wire logic                                       aresetn,
  input  wire logic                                       link_clk,
  input  wire logic                                       awvalid,
  output logic                                            awready,
  input  wire logic [ethernet_reset_pkg::ADDR_W-1:0]      awaddr,
  input  wire logic [2:0]                                 awprot,
  input  wire logic                                       wvalid,
  output logic                                            wready,
  input  wire logic [ethernet_reset_pkg::DATA_W-1:0]      wdata,
  input  wire logic [3:0]                                 wstrb,
  output logic                                            bvalid,
  input  wire logic                                       bready,
  output logic      [1:0]                                 bresp,
  input  wire logic                                       arvalid,
  output logic                                            arready,
  input  wire logic [ethernet_reset_pkg::ADDR_W-1:0]      araddr,
  input  wire logic [2:0]                                 arprot,
  output logic                                            rvalid,
  input  wire logic                                       rready,
  output logic      [ethernet_reset_pkg::DATA_W-1:0]      rdata,
  output logic      [1:0]                                 rresp,
  output logic                                            kernel_reset,
  output logic      [ethernet_reset_pkg::PHY_SEL_W-1:0]   phy_interface_select,
  output logic                                            link_reset,
  output logic      [ethernet_reset_pkg::PHY_SEL_W-1:0]   link_phy_select
);

  localparam int unsigned AW = ethernet_reset_pkg::ADDR_W;
  localparam int unsigned DW = ethernet_reset_pkg::DATA_W;
  localparam int unsigned PW = ethernet_reset_pkg::PHY_SEL_W;

  generate
    if (LINK_HOLD < 1) begin : g_bad
      $error("ethernet_reset_and_reg_sync: LINK_HOLD must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic          awready;
    logic          aw_have;
    logic [AW-1:0] aw_addr;
    logic          aw_priv;
    logic          wready;
    logic          w_have;
    logic [DW-1:0] w_data;
    logic          w_en;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [DW-1:0] rdata;
    logic [1:0]    rresp;
    logic          req_a;
    logic          req_b;
    logic          flag;
    logic          lock;
    logic [PW-1:0] phy_sel;
    logic [PW-1:0] cfg_word;
    logic          cfg_tgl;
    logic          soft_reset_request;
    logic          kreset;
    logic          rst_tgl;
    logic          rst_pend;
    logic          rack_m;
    logic          rack_s;
    logic          cack_m;
    logic          cack_s;
  } sys_s;

  sys_s q;
  sys_s d;
  logic rack_link;
  logic cack_link;

  // Word-aligned address match
  function automatic logic hit(input logic [AW-1:0] addr, input logic [AW-1:0] off);
    hit = (addr[AW-1:2] == off[AW-1:2]);
  endfunction : hit

  // ==========================================================================
  // Next state
  always_comb begin
    logic          allowed;
    logic [DW-1:0] rd;
    logic [1:0]    rr;
    allowed = 1'b0;
    rd      = '0;
    rr      = ethernet_reset_pkg::RESP_OKAY;
    d        = q;
    d.kreset = 1'b0;
    d.rack_m = rack_link;
    d.rack_s = q.rack_m;
    d.cack_m = cack_link;
    d.cack_s = q.cack_m;

    if (awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = awaddr;
      d.aw_priv = awprot[ethernet_reset_pkg::PRIV_PROT_BIT];
    end
    if (wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = wdata;
      d.w_en   = wstrb[0];
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end

    // Register writes
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = ethernet_reset_pkg::RESP_OKAY;
      allowed   = q.aw_priv && !q.lock; // [RULE5]
      if (hit(q.aw_addr, ethernet_reset_pkg::KERNEL_RESET_CTRL_A_OFF)) begin
        if (!allowed) begin
          d.bresp = ethernet_reset_pkg::RESP_SLVERR; // [RULE5]
        end else if (q.w_en) begin
          d.req_a = q.w_data[ethernet_reset_pkg::RESET_REQ_BIT];
        end
      end else if (hit(q.aw_addr, ethernet_reset_pkg::KERNEL_RESET_CTRL_B_OFF)) begin
        if (!allowed) begin
          d.bresp = ethernet_reset_pkg::RESP_SLVERR; // [RULE5]
        end else if (q.w_en) begin
          d.req_b = q.w_data[ethernet_reset_pkg::RESET_REQ_BIT];
        end
      end else if (hit(q.aw_addr, ethernet_reset_pkg::KERNEL_RESET_FLAG_CLR_OFF)) begin
        if (!allowed) begin
          d.bresp = ethernet_reset_pkg::RESP_SLVERR; // [RULE5]
        end else if (q.w_en && q.w_data[ethernet_reset_pkg::FLAG_CLEAR_BIT]) begin
          d.flag = 1'b0; // [RULE6]
        end
      end else if (hit(q.aw_addr, ethernet_reset_pkg::INIT_LOCK_OFF)) begin
        if (!q.aw_priv) begin
          d.bresp = ethernet_reset_pkg::RESP_SLVERR;
        end else if (q.w_en) begin
          d.lock = q.w_data[ethernet_reset_pkg::LOCK_BIT];
        end
      end else if (hit(q.aw_addr, ethernet_reset_pkg::PORT_CONTROL_OFF)) begin
        if (q.w_en) begin
          d.phy_sel = q.w_data[ethernet_reset_pkg::PHY_SEL_LSB +: PW];
          // Destination updated only when the previous word has landed
          if (q.cfg_tgl == q.cack_s) begin
            d.cfg_word = q.w_data[ethernet_reset_pkg::PHY_SEL_LSB +: PW];
            d.cfg_tgl  = ~q.cfg_tgl;
          end // [RULE10]
        end
      end else if (hit(q.aw_addr, ethernet_reset_pkg::DMA_MODE_OFF)) begin
        if (q.w_en && q.w_data[ethernet_reset_pkg::SOFT_RESET_BIT] && !q.soft_reset_request) begin
          d.soft_reset_request      = 1'b1; // [RULE8]
          d.rst_pend = 1'b1;
        end
      end else begin
        d.bresp = ethernet_reset_pkg::RESP_SLVERR;
      end
    end

    // Kernel reset: both requests present
    if (q.req_a && q.req_b) begin
      d.kreset  = 1'b1; // [RULE6]
      d.flag    = 1'b1; // [RULE6]
      d.req_a   = 1'b0;
      d.req_b   = 1'b0;
      d.phy_sel = ethernet_reset_pkg::PHY_SEL_MII;
      d.rst_pend = 1'b1;
    end

    // Link-domain reset launch and completion
    if (q.rst_pend && (q.rst_tgl == q.rack_s)) begin
      d.rst_tgl  = ~q.rst_tgl;
      d.rst_pend = 1'b0;
    end
    if (q.soft_reset_request && !q.rst_pend && (q.rst_tgl == q.rack_s)) begin
      d.soft_reset_request = 1'b0; // [RULE13]
    end

    // Register reads
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      if (hit(araddr, ethernet_reset_pkg::KERNEL_RESET_CTRL_A_OFF)) begin
        rd[ethernet_reset_pkg::RESET_REQ_BIT]  = q.req_a;
        rd[ethernet_reset_pkg::RESET_FLAG_BIT] = q.flag;
      end else if (hit(araddr, ethernet_reset_pkg::KERNEL_RESET_CTRL_B_OFF)) begin
        rd[ethernet_reset_pkg::RESET_REQ_BIT] = q.req_b;
      end else if (hit(araddr, ethernet_reset_pkg::KERNEL_RESET_FLAG_CLR_OFF)) begin
        rd = '0;
      end else if (hit(araddr, ethernet_reset_pkg::INIT_LOCK_OFF)) begin
        rd[ethernet_reset_pkg::LOCK_BIT] = q.lock;
      end else if (hit(araddr, ethernet_reset_pkg::PORT_CONTROL_OFF)) begin
        rd[ethernet_reset_pkg::PHY_SEL_LSB +: PW] = q.phy_sel; // [RULE10]
      end else if (hit(araddr, ethernet_reset_pkg::DMA_MODE_OFF)) begin
        rd[ethernet_reset_pkg::SOFT_RESET_BIT] = q.soft_reset_request; // [RULE8]
      end else begin
        rr = ethernet_reset_pkg::RESP_SLVERR;
      end
      d.rvalid = 1'b1;
      d.rdata  = rd;
      d.rresp  = rr;
    end

    d.awready = ~d.aw_have;
    d.wready  = ~d.w_have;
    d.arready = ~d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.lock    <= ethernet_reset_pkg::LOCK_RESET;
      q.phy_sel <= ethernet_reset_pkg::PHY_SEL_MII;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Link clock domain
  link_reset_bridge #(
    .CFG_W       (PW),
    .HOLD_CYCLES (LINK_HOLD)
  ) u_link (
    .link_clk   (link_clk),
    .aresetn    (aresetn),
    .rst_tgl    (q.rst_tgl),
    .cfg_tgl    (q.cfg_tgl),
    .cfg_data   (q.cfg_word),
    .rst_ack    (rack_link),
    .cfg_ack    (cack_link),
    .link_reset (link_reset),
    .link_cfg   (link_phy_select)
  );

  assign awready              = q.awready;
  assign wready               = q.wready;
  assign bvalid               = q.bvalid;
  assign bresp                = q.bresp;
  assign arready              = q.arready;
  assign rvalid               = q.rvalid;
  assign rdata                = q.rdata;
  assign rresp                = q.rresp;
  assign kernel_reset         = q.kreset;
  assign phy_interface_select = q.phy_sel;

endmodule : ethernet_reset_and_reg_sync

// >>> tb/phy_clock_model.sv
// =====================================================
// PHY transceiver clock source for the link domain
// Assumes the transceiver clock runs free, as PHY clocks do
`timescale 1ns/10ps
module phy_clock_model #(
  parameter real HALF = 3.0
) (
  output logic link_clk
);
  // =====================================================
  // Free-running clock, one clock stands for rx, tx and ref
  initial begin
    link_clk = 1'b0;
    forever #(HALF) link_clk = ~link_clk;
  end
endmodule : phy_clock_model

// >>> tb/ethernet_reset_and_reg_sync_asserts.sv
// =====================================================
// Checker for the reset and register-write control block
// Assumes binding to ethernet_reset_and_reg_sync ports
`timescale 1ns/10ps
module ethernet_reset_and_reg_sync_asserts #(
  parameter int unsigned LINK_HOLD = 8
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        link_clk,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        kernel_reset,
  input wire logic [1:0]  phy_interface_select,
  input wire logic        link_reset
);
  // =====================================================
  // Link reset length counter
  logic [7:0] hold_q;
  always_ff @(posedge link_clk) begin
    hold_q <= link_reset ? hold_q + 8'h01 : 8'h00;
  end
  // =====================================================
  // Properties
  a_bresp_held: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
  a_rdata_held: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready |=> rvalid && !arready) else $error("read answer late");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("write answer late");
  a_kr_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    kernel_reset |=> !kernel_reset) else $error("kernel reset not one cycle");
  a_kr_phy_mii: assert property (@(posedge aclk) disable iff (!aresetn)
    kernel_reset |=> phy_interface_select == 2'h0) else $error("phy select kept over kernel reset");
  a_kr_to_link: assert property (@(posedge link_clk) disable iff (!aresetn)
    $rose(kernel_reset) |-> ##[1:60] link_reset) else $error("link reset not launched");
  a_link_hold: assert property (@(posedge link_clk) disable iff (!aresetn)
    $fell(link_reset) |-> hold_q == LINK_HOLD) else $error("link reset length wrong");
endmodule : ethernet_reset_and_reg_sync_asserts

bind ethernet_reset_and_reg_sync ethernet_reset_and_reg_sync_asserts #(.LINK_HOLD(LINK_HOLD)) chk_i (
  .aclk(aclk), .aresetn(aresetn), .link_clk(link_clk), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .kernel_reset(kernel_reset), .phy_interface_select(phy_interface_select), .link_reset(link_reset));

// >>> tb/ethernet_reset_and_reg_sync_tb.sv
// =====================================================
// Bench for the reset and register-write control block
// Assumes the PHY clock model and the bound checker
`timescale 1ns/10ps
module ethernet_reset_and_reg_sync_tb;
  logic        aclk, aresetn, link_clk, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, kernel_reset, link_reset;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, phy_interface_select, link_phy_select, r;
  int          n_mismatch, checked, cyc, n_kr, n_lr;

  ethernet_reset_and_reg_sync uut (.aclk(aclk), .aresetn(aresetn), .link_clk(link_clk),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .kernel_reset(kernel_reset),
    .phy_interface_select(phy_interface_select), .link_reset(link_reset), .link_phy_select(link_phy_select));
  phy_clock_model phy (.link_clk(link_clk));

  // =====================================================
  // Clock, event counters and timeout
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (kernel_reset === 1'b1) n_kr++;
    if (cyc > 3000) begin
      n_mismatch++;
      test_done;
    end
  end
  always @(posedge link_reset) n_lr++;

  // =====================================================
  // Compare, bus tasks and verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [2:0] p, input logic [1:0] e);
    logic aw_d, w_d;
    awaddr <= a; wdata <= v; awprot <= p;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    aw_d = 1'b0; w_d = 1'b0;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (!aw_d && awready) begin aw_d = 1'b1; awvalid <= 1'b0; end
      if (!w_d && wready) begin w_d = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, e});
  endtask : wr

  task automatic rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata; r = rresp;
  endtask : rd

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  // =====================================================
  // Test sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, awprot, arprot, wdata} = '0;
    wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ethernet_reset_pkg::INIT_LOCK_OFF); chk(d, 32'h1);
    rd(ethernet_reset_pkg::PORT_CONTROL_OFF); chk(d, 32'h0);
    rd(8'h40); chk({d[29:0], r}, {30'h0, ethernet_reset_pkg::RESP_SLVERR});
    wr(ethernet_reset_pkg::PORT_CONTROL_OFF, 32'h1, 3'h1, ethernet_reset_pkg::RESP_OKAY);
    wr(ethernet_reset_pkg::DMA_MODE_OFF, 32'h1, 3'h1, ethernet_reset_pkg::RESP_OKAY);
    repeat (4) @(posedge aclk);
    do rd(ethernet_reset_pkg::DMA_MODE_OFF); while (d[0] !== 1'b0);
    chk(d, 32'h0);
    chk(n_lr, 1);
    wr(ethernet_reset_pkg::KERNEL_RESET_CTRL_A_OFF, 32'h1, 3'h1, ethernet_reset_pkg::RESP_SLVERR);
    wr(ethernet_reset_pkg::INIT_LOCK_OFF, 32'h0, 3'h0, ethernet_reset_pkg::RESP_SLVERR);
    wr(ethernet_reset_pkg::INIT_LOCK_OFF, 32'h0, 3'h1, ethernet_reset_pkg::RESP_OKAY);
    wr(ethernet_reset_pkg::KERNEL_RESET_CTRL_A_OFF, 32'h1, 3'h0, ethernet_reset_pkg::RESP_SLVERR);
    wr(ethernet_reset_pkg::PORT_CONTROL_OFF, 32'h1, 3'h1, ethernet_reset_pkg::RESP_OKAY);
    wr(ethernet_reset_pkg::KERNEL_RESET_CTRL_A_OFF, 32'h1, 3'h1, ethernet_reset_pkg::RESP_OKAY);
    chk(n_kr, 0);
    wr(ethernet_reset_pkg::KERNEL_RESET_CTRL_B_OFF, 32'h1, 3'h1, ethernet_reset_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(n_kr, 1);
    rd(ethernet_reset_pkg::KERNEL_RESET_CTRL_A_OFF); chk(d, 32'h2);
    rd(ethernet_reset_pkg::PORT_CONTROL_OFF); chk(d, 32'h0);
    wr(ethernet_reset_pkg::KERNEL_RESET_FLAG_CLR_OFF, 32'h1, 3'h1, ethernet_reset_pkg::RESP_OKAY);
    rd(ethernet_reset_pkg::KERNEL_RESET_CTRL_A_OFF); chk(d, 32'h0);
    repeat (70) @(posedge aclk);
    wr(ethernet_reset_pkg::PORT_CONTROL_OFF, 32'h0, 3'h1, ethernet_reset_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({30'h0, link_phy_select}, 32'h0);
    wr(ethernet_reset_pkg::PORT_CONTROL_OFF, 32'h1, 3'h1, ethernet_reset_pkg::RESP_OKAY);
    chk({30'h0, phy_interface_select}, 32'h1);
    repeat (2) @(posedge aclk);
    rd(ethernet_reset_pkg::PORT_CONTROL_OFF); chk(d, 32'h1);
    chk({30'h0, link_phy_select}, 32'h1);
    n_lr = 0;
    wr(ethernet_reset_pkg::DMA_MODE_OFF, 32'h1, 3'h1, ethernet_reset_pkg::RESP_OKAY);
    rd(ethernet_reset_pkg::DMA_MODE_OFF); chk(d, 32'h1);
    repeat (4) @(posedge aclk);
    do rd(ethernet_reset_pkg::DMA_MODE_OFF); while (d[0] !== 1'b0);
    chk(d, 32'h0);
    chk(n_lr, 1);
    chk({30'h0, link_phy_select}, 32'h1);
    test_done;
  end
endmodule : ethernet_reset_and_reg_sync_tb
